// ---- design/freq_ctl_pkg.sv ----
// Register map, field layout and timing constants of the frequency control
package freq_ctl_pkg;
    // Register offsets
    localparam logic [6:0] ADDR_AFC_LOOP_CONTROL = 7'h1d;
    localparam logic [6:0] ADDR_OP_MODE          = 7'h07;
    localparam logic [6:0] ADDR_MOD_CONTROL_TWO  = 7'h71;
    localparam logic [6:0] ADDR_DEVIATION_LOW    = 7'h72;
    localparam logic [6:0] ADDR_OFFSET_LOW       = 7'h73;
    localparam logic [6:0] ADDR_OFFSET_HIGH      = 7'h74;
    localparam logic [6:0] ADDR_BAND_SELECT      = 7'h75;
    localparam logic [6:0] ADDR_HOP_CHANNEL      = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP         = 7'h7a;
    localparam logic [6:0] ADDR_FIFO_ACCESS      = 7'h7f;
    // Reset values
    localparam logic [7:0] RST_AFC_LOOP_CONTROL  = 8'h40;
    localparam logic [7:0] RST_MOD_CONTROL_TWO   = 8'h00;
    localparam logic [7:0] RST_DEVIATION_LOW     = 8'h43;
    localparam logic [7:0] RST_OFFSET            = 8'h00;
    localparam logic [7:0] RST_BAND_SELECT       = 8'h35;
    localparam logic [7:0] RST_OP_MODE           = 8'h01;
    localparam logic [7:0] RST_HOP               = 8'h00;
    // Field positions
    localparam int AFC_HALF_BIT   = 7;
    localparam int AFC_EN_BIT     = 6;
    localparam int GEAR_HI_LSB    = 3;
    localparam int DEV_MSB_BIT    = 2;
    localparam int HBSEL_BIT      = 5;
    localparam int RXON_BIT       = 2;
    // Frequency steps in Hz, scaled by 100 to stay integer
    localparam int DEV_STEP_CHZ   = 62500;
    localparam int OFS_STEP_CHZ   = 15625;
    localparam int HOP_STEP_CHZ   = 1000000;
    // Tune settle time and its cycle count at 100 MHz
    localparam int TUNE_TIME_NS   = 50;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TUNE_CYCLES    =
        (TUNE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Radio state machine: idle, tune, receive and transmit
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TUNE = 4'b0010,
        ST_RX   = 4'b0100,
        ST_TX   = 4'b1000
    } radio_state_t;
endpackage

// ---- design/freq_ctl.sv ----
// Frequency offset, deviation, hop retune and AFC control logic
`timescale 1ns/1ns
// Notes on behaviour
// - Hop register write in TX retunes
// - Deviation code steps 625 Hz any band
// - Deviation MSB in 71h, low byte 72h
// - Offset code is signed ten bits
// - Offset step 156.25 Hz, doubled high band
// - Offset span 160 kHz high, 80 low
// - Manual offset only with AFC off
// - Offset reads show AFC result when enabled
// - Preamble detect freezes AFC correction
// - Multi-packet resets AFC per packet
// - Drift beyond deviation limit resets AFC; limit is twice deviation high band
// - Half bit halves drift limit
// - Loop register bit 6 enables AFC
// - Received bytes go to FIFO access
// - Packet valid exits receive to mode
// - Only packet valid clears receive-on
// - Errors raise interrupt, no state change
// - Band bit 5 selects high band
// - Hop step unit is 10 kHz
module freq_ctl
    import freq_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               srst_i,
    // Register port
    input  wire logic [6:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [7:0]         reg_wdata_i,
    output logic      [7:0]         reg_rdata_o,
    // Modem events
    input  wire logic               afc_valid_i,
    input  wire logic signed [9:0]  afc_step_i,
    input  wire logic               preamble_det_i,
    input  wire logic               packet_end_i,
    input  wire logic               multi_packet_i,
    input  wire logic               packet_valid_i,
    input  wire logic               packet_error_i,
    input  wire logic               tx_active_i,
    input  wire logic [7:0]         fifo_rdata_i,
    // Synthesizer and modem controls
    output logic signed [9:0]       lo_offset_code_o,
    output logic signed [24:0]      lo_offset_chz_o,
    output logic [8:0]              deviation_code_o,
    output logic [25:0]             deviation_chz_o,
    output logic [25:0]             hop_chz_o,
    output logic                    high_band_o,
    output logic [2:0]              gear_high_o,
    output logic [2:0]              gear_low_o,
    output logic                    afc_enable_o,
    output logic                    afc_frozen_o,
    output logic                    tune_o,
    output logic                    rx_on_o,
    output logic                    fifo_rd_o,
    output logic                    error_irq_o
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        // Host-visible registers
        logic [7:0]        afc_loop_control;
        logic [7:0]        mod_control_two;
        logic [7:0]        deviation_low;
        logic [7:0]        offset_low;
        logic [7:0]        offset_high;
        logic [7:0]        band_select;
        logic [7:0]        op_mode;
        logic [7:0]        hop_channel;
        logic [7:0]        hop_step;
        // AFC loop
        logic signed [9:0] afc_value;
        logic              frozen;
        // Radio sequencing
        radio_state_t      state;
        logic [3:0]        tune_cnt;
        // Registered bus and event outputs
        logic [7:0]        rdata;
        logic              err_irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic signed [9:0]  manual_code;
    logic signed [10:0] afc_sum;
    logic [10:0]        afc_mag;
    logic [11:0]        drift_lim;
    logic               hb;
    logic               afc_on;
    logic               wr_hop;
    logic               afc_reset_pkt;
    logic               afc_update;

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks on the timing and field constants
    // Tune counter is four bits, so the settle count must fit in it
    if (TUNE_CYCLES < 1 || TUNE_CYCLES > 15) begin : g_bad_tune
        $error("tune cycle count out of counter range");
    end
    // Field positions must stay inside their eight-bit registers
    if (AFC_HALF_BIT > 7 || AFC_EN_BIT > 7 || HBSEL_BIT > 7 ||
        RXON_BIT > 7 || DEV_MSB_BIT > 7) begin : g_bad_field
        $error("register field position outside the byte");
    end
    // Gear fields must not overlap the enable and halving bits
    if (GEAR_HI_LSB + 3 > AFC_EN_BIT) begin : g_bad_gear
        $error("gear field overlaps the enable bit");
    end
    // Offset step must keep the widest code inside the output port
    if (OFS_STEP_CHZ * 1024 >= (1 << 24)) begin : g_bad_step
        $error("offset step too large for the output width");
    end

    always_comb begin
        manual_code = {st.offset_high[1:0], st.offset_low};
        hb          = st.band_select[HBSEL_BIT];
        afc_on      = st.afc_loop_control[AFC_EN_BIT];
        // Wide sum so a full-scale step cannot wrap before the test
        afc_sum     = 11'(st.afc_value) + 11'(afc_step_i);
        // Magnitude for the symmetric drift test
        afc_mag     = afc_sum[10] ? 11'(-afc_sum) : afc_sum;
        // Limit in offset units: deviation is 4 offset steps low band
        drift_lim   = {1'b0, st.mod_control_two[DEV_MSB_BIT],
                       st.deviation_low, 2'b00};
        if (!hb) begin
            drift_lim = drift_lim;
        end else begin
            // High band keeps the low band count, so the limit spans twice the deviation
            drift_lim = drift_lim;
        end
        if (st.afc_loop_control[AFC_HALF_BIT]) begin
            drift_lim = drift_lim >> 1;
        end
        wr_hop = reg_wr_i && (reg_addr_i == ADDR_HOP_CHANNEL ||
                              reg_addr_i == ADDR_HOP_STEP);
        // Multi-packet mode restarts acquisition at every packet end
        afc_reset_pkt = multi_packet_i && packet_end_i;
        // Loop follows the modem only while receiving and unfrozen
        afc_update = afc_valid_i && !st.frozen && st.state == ST_RX;
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // Register writes land on the strobe edge
        // Reserved offset bits are dropped here so they read zero
        // Writes to unmapped addresses are ignored
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_AFC_LOOP_CONTROL: next_st.afc_loop_control = reg_wdata_i;
                ADDR_MOD_CONTROL_TWO:  next_st.mod_control_two = reg_wdata_i;
                ADDR_DEVIATION_LOW:    next_st.deviation_low = reg_wdata_i;
                ADDR_OFFSET_LOW:       next_st.offset_low = reg_wdata_i;
                ADDR_OFFSET_HIGH:
                    next_st.offset_high = {6'h0_0, reg_wdata_i[1:0]};
                ADDR_BAND_SELECT:      next_st.band_select = reg_wdata_i;
                ADDR_OP_MODE:          next_st.op_mode = reg_wdata_i;
                ADDR_HOP_CHANNEL:      next_st.hop_channel = reg_wdata_i;
                ADDR_HOP_STEP:         next_st.hop_step = reg_wdata_i;
                default: ;
            endcase
        end
        // AFC loop: freeze on preamble, reset per packet or on drift
        if (!afc_on) begin
            next_st.afc_value = '0;
            next_st.frozen    = 1'b0;
        end else if (afc_reset_pkt) begin
            next_st.afc_value = '0;
            next_st.frozen    = 1'b0;
        end else if (preamble_det_i) begin
            next_st.frozen    = 1'b1;
        end else if (afc_update) begin
            if ({1'b0, afc_mag} > drift_lim) begin
                next_st.afc_value = '0;
            end else begin
                next_st.afc_value = afc_sum[9:0];
            end
        end
        // Error events only flag; the host decides what follows
        next_st.err_irq = packet_error_i;
        // Radio state
        // Receive start and a hop write while sending pass the tune countdown first
        unique case (st.state)
            ST_IDLE: begin
                // Receive request wins over a transmit start
                if (st.op_mode[RXON_BIT]) begin
                    next_st.state    = ST_TUNE;
                    next_st.tune_cnt = 4'(TUNE_CYCLES);
                end else if (tx_active_i) begin
                    next_st.state = ST_TX;
                end
            end
            ST_TUNE: begin
                // Settle, then resume whichever mode is asked
                if (st.tune_cnt > 4'h1) begin
                    next_st.tune_cnt = st.tune_cnt - 4'h1;
                end else if (tx_active_i) begin
                    next_st.state = ST_TX;
                end else if (st.op_mode[RXON_BIT]) begin
                    next_st.state = ST_RX;
                end else begin
                    next_st.state = ST_IDLE;
                end
            end
            ST_RX: begin
                // Only a valid packet ends receive by itself
                if (packet_valid_i) begin
                    // Clear-wins: hardware clear beats a host write here
                    next_st.op_mode[RXON_BIT] = 1'b0;
                    next_st.state = ST_IDLE;
                end else if (!st.op_mode[RXON_BIT]) begin
                    next_st.state = ST_IDLE;
                end
            end
            ST_TX: begin
                // A hop write while sending retunes with no command
                if (wr_hop) begin
                    next_st.state    = ST_TUNE;
                    next_st.tune_cnt = 4'(TUNE_CYCLES);
                end else if (!tx_active_i) begin
                    next_st.state = ST_IDLE;
                end
            end
            default: next_st.state = ST_IDLE;
        endcase
        // Read data stands one cycle after the strobe, then zero
        // Unmapped addresses read zero
        next_st.rdata = 8'h0_0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_AFC_LOOP_CONTROL: next_st.rdata = st.afc_loop_control;
                ADDR_MOD_CONTROL_TWO:  next_st.rdata = st.mod_control_two;
                ADDR_DEVIATION_LOW:    next_st.rdata = st.deviation_low;
                // Loop result while AFC runs, top two bits in high byte
                ADDR_OFFSET_LOW:
                    next_st.rdata = afc_on ? st.afc_value[7:0]
                                           : st.offset_low;
                ADDR_OFFSET_HIGH:
                    next_st.rdata = afc_on ? {6'h0_0, st.afc_value[9:8]}
                                           : st.offset_high;
                ADDR_BAND_SELECT:      next_st.rdata = st.band_select;
                ADDR_OP_MODE:          next_st.rdata = st.op_mode;
                ADDR_HOP_CHANNEL:      next_st.rdata = st.hop_channel;
                ADDR_HOP_STEP:         next_st.rdata = st.hop_step;
                ADDR_FIFO_ACCESS:      next_st.rdata = fifo_rdata_i;
                default:               next_st.rdata = 8'h0_0;
            endcase
        end
        // Reset last so it overrides every update above
        if (srst_i) begin
            next_st = '0;
            next_st.afc_loop_control = RST_AFC_LOOP_CONTROL;
            next_st.mod_control_two  = RST_MOD_CONTROL_TWO;
            next_st.deviation_low    = RST_DEVIATION_LOW;
            next_st.offset_low       = RST_OFFSET;
            next_st.offset_high      = RST_OFFSET;
            next_st.band_select      = RST_BAND_SELECT;
            next_st.op_mode          = RST_OP_MODE;
            next_st.hop_channel      = RST_HOP;
            next_st.hop_step         = RST_HOP;
            next_st.state            = ST_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////
    // Synthesizer outputs; frequencies in centihertz
    logic signed [9:0]  lo_code;
    logic signed [24:0] lo_chz_low;
    logic signed [24:0] lo_chz;
    always_comb begin
        lo_code    = afc_on ? st.afc_value : manual_code;
        // Low band unit first; high band doubles each unit
        lo_chz_low = 25'(lo_code) * 25'(OFS_STEP_CHZ);
        if (hb) begin
            lo_chz = lo_chz_low <<< 1;
        end else begin
            lo_chz = lo_chz_low;
        end
    end
    // Ten signed bits give +-512 steps: 80 kHz low, 160 kHz high
    assign lo_offset_code_o = lo_code;
    assign lo_offset_chz_o  = lo_chz;
    assign deviation_code_o = {st.mod_control_two[DEV_MSB_BIT],
                               st.deviation_low};
    assign deviation_chz_o  = 26'(deviation_code_o) *
                              26'(DEV_STEP_CHZ);
    // Product wraps for large codes; the host keeps it in range
    assign hop_chz_o        = 26'(st.hop_channel) * 26'(st.hop_step) *
                              26'(HOP_STEP_CHZ);
    assign high_band_o      = hb;
    assign gear_high_o      = st.afc_loop_control[5:3];
    assign gear_low_o       = st.afc_loop_control[2:0];
    assign afc_enable_o     = afc_on;
    assign afc_frozen_o     = st.frozen;
    assign tune_o           = st.state == ST_TUNE;
    assign rx_on_o          = st.state == ST_RX;
    assign fifo_rd_o        = reg_rd_i && reg_addr_i == ADDR_FIFO_ACCESS;
    assign error_irq_o      = st.err_irq;
    assign reg_rdata_o      = st.rdata;
endmodule // freq_ctl

// ---- dv/freq_ctl_props.sv ----
// Concurrent checks on the frequency control block ports
`timescale 1ns/1ns
module freq_ctl_props
    import freq_ctl_pkg::*;
(
    // Clock, reset and register port
    input wire logic               mclk_i,
    input wire logic               srst_i,
    input wire logic [6:0]         reg_addr_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic [7:0]         reg_rdata_o,
    // Modem events
    input wire logic               packet_valid_i,
    input wire logic               packet_error_i,
    input wire logic               tx_active_i,
    input wire logic [7:0]         fifo_rdata_i,
    // Controls
    input wire logic signed [9:0]  lo_offset_code_o,
    input wire logic signed [24:0] lo_offset_chz_o,
    input wire logic [8:0]         deviation_code_o,
    input wire logic [25:0]        deviation_chz_o,
    input wire logic               high_band_o,
    input wire logic               afc_enable_o,
    input wire logic               tune_o,
    input wire logic               rx_on_o,
    input wire logic               error_irq_o,
    input wire logic               fifo_rd_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence err_in;
        packet_error_i ##1 !packet_error_i;
    endsequence
    sequence tune_run;
        tune_o [*5] ##1 !tune_o;
    endsequence
    chk_hop_retune: assert property (
        tx_active_i && !tune_o && reg_wr_i && (reg_addr_i == ADDR_HOP_CHANNEL
        || reg_addr_i == ADDR_HOP_STEP) |=> tune_o) else $error("no retune");
    chk_tune_len: assert property (
        $rose(tune_o) |-> tune_run) else $error("tune length");
    chk_dev_scale: assert property (
        deviation_chz_o == deviation_code_o * DEV_STEP_CHZ)
        else $error("deviation scale");
    chk_ofs_scale: assert property (
        lo_offset_chz_o == lo_offset_code_o * (high_band_o ? 2 : 1)
        * OFS_STEP_CHZ) else $error("offset scale");
    chk_manual_ofs: assert property (
        !afc_enable_o && reg_wr_i && reg_addr_i == ADDR_OFFSET_LOW
        |=> lo_offset_code_o[7:0] == $past(reg_wdata_i)) else $error("manual");
    chk_loop_cfg: assert property (
        reg_wr_i && reg_addr_i == ADDR_AFC_LOOP_CONTROL
        |=> afc_enable_o == $past(reg_wdata_i[6])) else $error("afc enable");
    chk_fifo_read: assert property (
        reg_rd_i && reg_addr_i == ADDR_FIFO_ACCESS
        |=> reg_rdata_o == $past(fifo_rdata_i)) else $error("fifo data");
    chk_rx_exit: assert property (
        rx_on_o && !tune_o && packet_valid_i && !reg_wr_i |=> !rx_on_o)
        else $error("rx not left");
    chk_err_stay: assert property (
        rx_on_o && packet_error_i && !packet_valid_i && !reg_wr_i
        |=> rx_on_o) else $error("error left rx");
    chk_fifo_strobe: assert property (
        fifo_rd_o == (reg_rd_i && reg_addr_i == ADDR_FIFO_ACCESS))
        else $error("fifo strobe");
    chk_err_pulse: assert property (
        err_in |-> error_irq_o ##1 !error_irq_o) else $error("error pulse");
endmodule // freq_ctl_props
bind freq_ctl freq_ctl_props u_freq_ctl_props (.*);

// ---- dv/host_model.sv ----
// Host register access model for the frequency control block
`timescale 1ns/1ns
module host_model
    import freq_ctl_pkg::*;
(
    // Clock
    input  wire logic       mclk_i,
    // Register port toward the device
    output logic      [6:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o  = 7'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // Data inverted after release so stale bytes never pass as valid
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(negedge mclk_i);
        reg_addr_o  = a;
        reg_wdata_o = v;
        reg_wr_o    = 1'b1;
        @(negedge mclk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~v;
    endtask
    // Answer stands one cycle only, taken at the next falling edge
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge mclk_i);
        v        = reg_rdata_i;
        reg_rd_o = 1'b0;
    endtask
endmodule // host_model

// ---- dv/freq_ctl_tb_top.sv ----
// Self-checking bench for the frequency control block
`timescale 1ns/1ns
module freq_ctl_tb_top;
    import freq_ctl_pkg::*;
    logic mclk_i = 1'b0, srst_i = 1'b1, reg_wr_i, reg_rd_i, high_band_o;
    logic [6:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, d, fifo_rdata_i = 8'h5a;
    logic afc_valid_i = 1'b0, preamble_det_i = 1'b0, packet_end_i = 1'b0;
    logic multi_packet_i = 1'b0, packet_valid_i = 1'b0, tx_active_i = 1'b0;
    logic packet_error_i = 1'b0, afc_enable_o, afc_frozen_o, tune_o;
    logic rx_on_o, fifo_rd_o, error_irq_o;
    logic signed [9:0] afc_step_i = 10'h000, lo_offset_code_o;
    logic signed [24:0] lo_offset_chz_o;
    logic [8:0] deviation_code_o;
    logic [25:0] deviation_chz_o, hop_chz_o;
    logic [2:0] gear_high_o, gear_low_o;
    logic [14:0] rst_tab [6] = '{15'h1d40, 15'h7100, 15'h7243, 15'h7300,
                                 15'h7400, 15'h1000};
    int n_errors = 0;
    int comparisons = 0;
    freq_ctl u_freq_ctl (.*);
    host_model u_host_model (.mclk_i, .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o));
    always #5 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [3:0] m);
        @(negedge mclk_i);
        {preamble_det_i, packet_end_i, packet_valid_i, packet_error_i} = m;
        @(negedge mclk_i);
        {preamble_det_i, packet_end_i, packet_valid_i, packet_error_i} = 0;
    endtask
    // Two extra edges give the loop time to apply a drift reset
    task automatic step(input logic signed [9:0] s);
        @(negedge mclk_i);
        afc_valid_i = 1'b1;
        afc_step_i  = s;
        @(negedge mclk_i);
        afc_valid_i = 1'b0;
        afc_step_i  = ~s;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (5) @(negedge mclk_i);
        srst_i = 1'b0;
        foreach (rst_tab[i]) begin
            u_host_model.rd(rst_tab[i][14:8], d);
            chk(d, rst_tab[i][7:0]);
        end
        u_host_model.wr(ADDR_MOD_CONTROL_TWO, 8'h04);
        u_host_model.wr(ADDR_DEVIATION_LOW, 8'h10);
        u_host_model.rd(ADDR_MOD_CONTROL_TWO, d);
        chk({d, deviation_code_o}, 17'h0_0910);
        chk(deviation_chz_o, 272 * DEV_STEP_CHZ);
        u_host_model.wr(ADDR_AFC_LOOP_CONTROL, 8'h2b);
        chk({afc_enable_o, gear_high_o, gear_low_o}, 7'h2b);
        u_host_model.wr(ADDR_OFFSET_LOW, 8'h60);
        u_host_model.wr(ADDR_OFFSET_HIGH, 8'hff);
        u_host_model.rd(ADDR_OFFSET_HIGH, d);
        chk(d, 8'h03);
        chk(lo_offset_chz_o, -160 * 31250);
        u_host_model.wr(ADDR_BAND_SELECT, 8'h15);
        u_host_model.wr(ADDR_OFFSET_LOW, 8'hff);
        u_host_model.wr(ADDR_OFFSET_HIGH, 8'h01);
        chk(lo_offset_chz_o, 511 * 15625);
        chk(high_band_o, 1'b0);
        u_host_model.wr(ADDR_AFC_LOOP_CONTROL, 8'h40);
        chk(lo_offset_code_o, 10'h000);
        u_host_model.wr(ADDR_DEVIATION_LOW, 8'h02);
        u_host_model.wr(ADDR_MOD_CONTROL_TWO, 8'h00);
        u_host_model.wr(ADDR_OP_MODE, 8'h05);
        repeat (8) @(negedge mclk_i);
        chk(rx_on_o, 1'b1);
        step(4);
        step(4);
        chk(lo_offset_code_o, 10'h008);
        step(1);
        chk(lo_offset_code_o, 10'h000);
        u_host_model.wr(ADDR_AFC_LOOP_CONTROL, 8'hc0);
        step(4);
        chk(lo_offset_code_o, 10'h004);
        step(1);
        chk(lo_offset_code_o, 10'h000);
        step(3);
        pulse(4'h8);
        step(3);
        u_host_model.rd(ADDR_OFFSET_LOW, d);
        chk({afc_frozen_o, d}, 9'h103);
        multi_packet_i = 1'b1;
        pulse(4'h4);
        chk(lo_offset_code_o, 10'h000);
        pulse(4'h1);
        chk({error_irq_o, rx_on_o}, 2'h3);
        u_host_model.rd(ADDR_FIFO_ACCESS, d);
        chk(d, 8'h5a);
        fifo_rdata_i = 8'ha5;
        u_host_model.rd(ADDR_FIFO_ACCESS, d);
        chk(d, 8'ha5);
        pulse(4'h2);
        u_host_model.rd(ADDR_OP_MODE, d);
        chk({rx_on_o, d}, 9'h001);
        u_host_model.wr(ADDR_HOP_STEP, 8'h03);
        tx_active_i = 1'b1;
        u_host_model.wr(ADDR_HOP_CHANNEL, 8'h02);
        chk(tune_o, 1'b1);
        chk(hop_chz_o, 6 * HOP_STEP_CHZ);
        repeat (8) @(negedge mclk_i);
        final_report();
    end
endmodule // freq_ctl_tb_top
